//--- inc/pmrb_pkg.sv
// Constants, field layouts and types shared by the readback block.
package pmrb_pkg;
  localparam int CMD_W = 29;
  localparam int RB_W = 24;
  localparam int PAD_W = 5;
  localparam int DAC_W = 16;
  localparam int NUM_CH = 4;
  localparam int SETS_PER_DAC = 6;
  localparam int NUM_SET = 12;
  localparam int DAC_REGS = 3;
  localparam int DAC_ENTRIES = 144;
  localparam int FLUSH_BITS = 24;
  localparam logic [4:0] CNT_SHORT = 5'h17;
  localparam logic [4:0] CNT_FULL = 5'h1c;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  localparam logic [5:0] LO_SET_BASE = 6'h20;
  localparam logic [5:0] HI_SET_BASE = 6'h28;
  localparam logic [1:0] OP_CTL = 2'h0;
  localparam logic [1:0] OP_GAIN = 2'h1;
  localparam logic [1:0] OP_OFFS = 2'h2;
  localparam logic [1:0] OP_INPUT = 2'h3;
  localparam logic [15:0] GAIN_MASK = 16'hfffe;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_LAST_CMD = 8'h08;
  localparam logic [7:0] ADR_SYS_CTRL = 8'h0c;
  localparam logic [7:0] ADR_CMP_STAT = 8'h10;
  localparam logic [7:0] ADR_ALM_STAT = 8'h14;
  localparam logic [7:0] ADR_CH0 = 8'h18;
  localparam logic [7:0] ADR_CH3 = 8'h24;
  localparam logic [7:0] ADR_DAC_SEL = 8'h28;
  localparam logic [7:0] ADR_DAC_DATA = 8'h2c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_BAD_BIT = 16;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [23:0] REG_RST = 24'h00_0000;
  localparam logic [7:0] SEL_RST = 8'h40;

  typedef struct packed {
    logic rd;
    logic [3:0] ch;
    logic [1:0] op;
    logic [5:0] addr;
    logic [15:0] data;
  } pmrb_cmd_t;

  typedef struct packed {
    logic [1:0] op;
    logic [3:0] set;
    logic [1:0] ch;
  } pmrb_dac_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TAKE = 2'b01,
    ST_DECODE = 2'b10
  } pmrb_state_t;
endpackage

//--- hdl/pmrb_link.sv
// Serial shifter running on the link clock.
`timescale 1ns/100ps
`default_nettype none
module pmrb_link
  import pmrb_pkg::*;
(
  input wire logic clk_link,
  input wire logic srst,
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic [RB_W-1:0] rb_word,
  input wire logic rb_tgl,
  output logic [CMD_W-1:0] cmd_word,
  output logic frame_tgl,
  output logic sdo
);
  logic [1:0] rst_sync_q;
  logic [1:0] tgl_sync_q;
  logic tgl_seen_q;
  logic [CMD_W-1:0] shift_q;
  logic [CMD_W-1:0] shift_d;
  logic [4:0] cnt_q;
  logic sdo_q;
  logic load_now;

  assign shift_d = {shift_q[CMD_W-2:0], sdi};
  assign load_now = sync_n && (tgl_sync_q[1] != tgl_seen_q);
  assign sdo = sdo_q;

  always_ff @(posedge clk_link) begin
    rst_sync_q <= {rst_sync_q[0], srst};
    tgl_sync_q <= {tgl_sync_q[0], rb_tgl};
  end

  // The word is loaded on an idle edge so its MSB is on sdo before the frame.
  always_ff @(posedge clk_link) begin
    if (rst_sync_q[1]) begin
      tgl_seen_q <= 1'b0;
      shift_q <= '0;
      sdo_q <= 1'b0;
    end else if (load_now) begin
      tgl_seen_q <= tgl_sync_q[1];
      sdo_q <= rb_word[RB_W-1];
      shift_q <= {rb_word[RB_W-2:0], {(PAD_W+1){1'b0}}};
    end else if (!sync_n) begin
      sdo_q <= shift_q[CMD_W-1];
      shift_q <= shift_d;
    end
  end

  // The count clears with the frame signal itself, since sclk may stop.
  always_ff @(posedge clk_link or posedge sync_n) begin
    if (sync_n) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_link) begin
    if (rst_sync_q[1]) begin
      cmd_word <= '0;
      frame_tgl <= 1'b0;
    end else if (!sync_n && (cnt_q == CNT_SHORT || cnt_q == CNT_FULL)) begin
      cmd_word <= shift_d;
      if (cnt_q == CNT_SHORT) begin
        frame_tgl <= ~frame_tgl;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/pmrb_top.sv
// Register readback command interpreter with Wishbone register access.
`timescale 1ns/100ps
`default_nettype none
module pmrb_top
  import pmrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_link,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] dac_idx(input logic [1:0] ch, input logic [3:0] set,
                                         input logic [1:0] op);
    logic [7:0] ch_part;
    logic [7:0] set_part;
    ch_part = 8'(ch) * 8'(NUM_SET * DAC_REGS);
    set_part = 8'(set) * 8'(DAC_REGS);
    return ch_part + set_part + 8'(op) - 8'h01;
  endfunction

  function automatic logic [1:0] ch_index(input logic [3:0] ch);
    logic [1:0] res;
    res = 2'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch[i]) begin
        res = 2'(i);
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Storage and state.

  logic [31:0] ctrl_q;
  logic [15:0] rb_count_q;
  logic bad_q;
  logic [CMD_W-1:0] last_cmd_q;
  logic [RB_W-1:0] sys_ctrl_q;
  logic [RB_W-1:0] cmp_stat_q;
  logic [RB_W-1:0] alm_stat_q;
  logic [RB_W-1:0] pmu_q [NUM_CH];
  logic [DAC_W-1:0] dac_q [DAC_ENTRIES];
  pmrb_dac_sel_t dac_sel_q;
  pmrb_state_t state_q;
  pmrb_cmd_t cmd_q;
  logic [RB_W-1:0] rb_word_q;
  logic rb_tgl_q;
  logic [2:0] sync_n_q;
  logic [2:0] frame_q;
  logic frame_seen_q;
  logic [CMD_W-1:0] link_cmd;
  logic link_frame_tgl;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wr_v;
  logic [7:0] sel_idx;
  logic frame_end;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign sel_idx = dac_idx(dac_sel_q.ch, dac_sel_q.set, dac_sel_q.op);

  //////////////////////////////////////////////////////////////////////////////
  // Link side shifter.

  pmrb_link u_link (
    .clk_link(clk_link),
    .srst(srst),
    .sync_n(sync_n),
    .sdi(sdi),
    .rb_word(rb_word_q),
    .rb_tgl(rb_tgl_q),
    .cmd_word(link_cmd),
    .frame_tgl(link_frame_tgl),
    .sdo(sdo)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Crossing of the frame end into the system clock.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_n_q <= 3'h7;
      frame_q <= 3'h0;
    end else begin
      sync_n_q <= {sync_n_q[1:0], sync_n};
      frame_q <= {frame_q[1:0], link_frame_tgl};
    end
  end

  assign frame_end = sync_n_q[1] && !sync_n_q[2] && (frame_q[1] != frame_seen_q);

  //////////////////////////////////////////////////////////////////////////////
  // Command decode.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
      frame_seen_q <= 1'b0;
      cmd_q <= '0;
      last_cmd_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (frame_end) begin
            frame_seen_q <= frame_q[1];
            state_q <= ST_TAKE;
          end
        end
        ST_TAKE: begin
          cmd_q <= pmrb_cmd_t'(link_cmd);
          last_cmd_q <= link_cmd;
          state_q <= ST_DECODE;
        end
        ST_DECODE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  logic rb_hit;
  logic rb_bad;
  logic [RB_W-1:0] rb_val;
  logic [3:0] set_no;
  logic set_ok;

  always_comb begin
    set_ok = 1'b0;
    set_no = 4'h0;
    if (cmd_q.addr >= LO_SET_BASE && cmd_q.addr < LO_SET_BASE + 6'(SETS_PER_DAC)) begin
      set_ok = 1'b1;
      set_no = 4'(cmd_q.addr - LO_SET_BASE);
    end else if (cmd_q.addr >= HI_SET_BASE && cmd_q.addr < HI_SET_BASE + 6'(SETS_PER_DAC)) begin
      set_ok = 1'b1;
      set_no = 4'(cmd_q.addr - HI_SET_BASE) + 4'(SETS_PER_DAC);
    end
  end

  always_comb begin
    rb_hit = 1'b0;
    rb_bad = 1'b0;
    rb_val = REG_RST;
    if (cmd_q.rd) begin
      if (cmd_q.ch == 4'h0) begin
        rb_hit = (cmd_q.addr == 6'h00) && (cmd_q.data == 16'h0000);
        case (cmd_q.op)
          OP_CTL: rb_val = sys_ctrl_q;
          OP_GAIN: rb_val = cmp_stat_q;
          OP_INPUT: rb_val = alm_stat_q;
          default: rb_hit = 1'b0;
        endcase
        rb_bad = !rb_hit;
      end else if ($onehot(cmd_q.ch)) begin
        if (cmd_q.op == OP_CTL) begin
          rb_hit = 1'b1;
          rb_val = pmu_q[ch_index(cmd_q.ch)];
        end else begin
          rb_hit = set_ok;
          rb_val = {cmd_q.op, cmd_q.addr,
                    dac_q[dac_idx(ch_index(cmd_q.ch), set_no, cmd_q.op)]};
        end
        rb_bad = !rb_hit;
      end else begin
        rb_bad = 1'b1;
      end
    end
  end

  // The word handed to the link only changes on a new readback command.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rb_word_q <= REG_RST;
      rb_tgl_q <= 1'b0;
    end else if (state_q == ST_DECODE && rb_hit && ctrl_q[CTRL_EN_BIT]) begin
      rb_word_q <= rb_val;
      rb_tgl_q <= ~rb_tgl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status counter and bad-command flag.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rb_count_q <= CNT_RST;
      bad_q <= 1'b0;
    end else begin
      if (state_q == ST_DECODE && rb_hit && ctrl_q[CTRL_EN_BIT]) begin
        rb_count_q <= rb_count_q + 16'h0001;
      end
      if (state_q == ST_DECODE && rb_bad) begin
        bad_q <= 1'b1;
      end else if (wb_wr && wb_adr_i == ADR_STATUS && wb_sel_i[2] && wb_dat_i[STAT_BAD_BIT]) begin
        bad_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone register writes.

  always_comb begin
    wr_v = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    case (wb_adr_i)
      ADR_CTRL: wr_v = merge(ctrl_q, wb_dat_i, wb_sel_i);
      ADR_SYS_CTRL: wr_v = merge({8'h00, sys_ctrl_q}, wb_dat_i, wb_sel_i);
      ADR_CMP_STAT: wr_v = merge({8'h00, cmp_stat_q}, wb_dat_i, wb_sel_i);
      ADR_ALM_STAT: wr_v = merge({8'h00, alm_stat_q}, wb_dat_i, wb_sel_i);
      ADR_DAC_SEL: wr_v = merge({24'h00_0000, dac_sel_q}, wb_dat_i, wb_sel_i);
      ADR_DAC_DATA: wr_v = merge({16'h0000, dac_q[sel_idx]}, wb_dat_i, wb_sel_i);
      default: wr_v = merge({8'h00, pmu_q[wb_adr_i[3:2] - 2'h2]}, wb_dat_i, wb_sel_i);
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
      sys_ctrl_q <= REG_RST;
      cmp_stat_q <= REG_RST;
      alm_stat_q <= REG_RST;
      dac_sel_q <= pmrb_dac_sel_t'(SEL_RST);
    end else if (wb_wr) begin
      case (wb_adr_i)
        ADR_CTRL: ctrl_q <= wr_v & CTRL_RST;
        ADR_SYS_CTRL: sys_ctrl_q <= wr_v[RB_W-1:0];
        ADR_CMP_STAT: cmp_stat_q <= wr_v[RB_W-1:0];
        ADR_ALM_STAT: alm_stat_q <= wr_v[RB_W-1:0];
        ADR_DAC_SEL: dac_sel_q <= pmrb_dac_sel_t'(wr_v[7:0]);
        default: begin
        end
      endcase
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_pmu
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          pmu_q[gc] <= REG_RST;
        end else if (wb_wr && wb_adr_i == ADR_CH0 + 8'(gc * 4)) begin
          pmu_q[gc] <= wr_v[RB_W-1:0];
        end
      end
    end
  endgenerate

  // Gain entries drop bit 0; a selection with op zero or a set out of range is ignored.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < DAC_ENTRIES; i++) begin
        dac_q[i] <= 16'h0000;
      end
    end else if (wb_wr && wb_adr_i == ADR_DAC_DATA && dac_sel_q.op != OP_CTL
                 && dac_sel_q.set < 4'(NUM_SET)) begin
      if (dac_sel_q.op == OP_GAIN) begin
        dac_q[sel_idx] <= wr_v[DAC_W-1:0] & GAIN_MASK;
      end else begin
        dac_q[sel_idx] <= wr_v[DAC_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone read data and acknowledge.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          ADR_CTRL: wb_dat_o <= ctrl_q;
          ADR_STATUS: wb_dat_o <= {15'h0000, bad_q, rb_count_q};
          ADR_LAST_CMD: wb_dat_o <= {3'h0, last_cmd_q};
          ADR_SYS_CTRL: wb_dat_o <= {8'h00, sys_ctrl_q};
          ADR_CMP_STAT: wb_dat_o <= {8'h00, cmp_stat_q};
          ADR_ALM_STAT: wb_dat_o <= {8'h00, alm_stat_q};
          ADR_DAC_SEL: wb_dat_o <= {24'h00_0000, dac_sel_q};
          ADR_DAC_DATA: wb_dat_o <= {16'h0000, dac_q[sel_idx]};
          default: begin
            if (wb_adr_i >= ADR_CH0 && wb_adr_i <= ADR_CH3 && wb_adr_i[1:0] == 2'h0) begin
              wb_dat_o <= {8'h00, pmu_q[wb_adr_i[3:2] - 2'h2]};
            end else begin
              wb_dat_o <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/pmrb_top_props.sv
// Port-level assertions for the readback block, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module pmrb_top_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_link,
  input wire logic sync_n,
  input wire logic sdo,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  logic [4:0] cnt_q;
  logic idle_q;
  logic last_sdo_q;
  logic loaded_q;
  logic sdo_neg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Counts link edges in the current frame; the count clears on the first idle edge.
  always_ff @(posedge clk_link) begin
    if (srst || sync_n) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_link) begin
    idle_q <= sync_n;
    last_sdo_q <= sdo;
  end

  // A change of sdo between frames can only be a load of a readback word.
  always_ff @(posedge clk_link) begin
    if (srst || (sync_n && cnt_q != 5'h00)) begin
      loaded_q <= 1'b0;
    end else if (sync_n && idle_q && sdo != last_sdo_q) begin
      loaded_q <= 1'b1;
    end
  end

  always_ff @(negedge clk_link) begin
    sdo_neg_q <= sdo;
  end

  ////////////////////////////////////////////////////////////////////////////
  ack_latency_a: assert property (@(posedge clk_sys) disable iff (srst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (@(posedge clk_sys) disable iff (srst)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  rd_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    !$stable(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i))
    else $error("read data moved");
  pad_zeros_a: assert property (@(posedge clk_link) disable iff (srst)
    loaded_q && cnt_q >= 5'h18 && cnt_q <= 5'h1c |-> sdo == 1'b0) else $error("pad not zero");
  full_shift_a: assert property (@(posedge clk_link) disable iff (srst)
    sync_n && loaded_q && cnt_q == 5'h1d |-> sdo == 1'b0) else $error("readback tail not zero");
  rise_only_a: assert property (@(posedge clk_link) disable iff (srst)
    sdo == sdo_neg_q) else $error("sdo moved off rising edge");
  word_hold_a: assert property (@(posedge clk_link) disable iff (srst)
    sync_n && idle_q && loaded_q |-> $stable(sdo)) else $error("loaded word altered");
endmodule

bind pmrb_top pmrb_top_props i_pmrb_top_props (.clk_sys(clk_sys), .srst(srst),
  .clk_link(clk_link), .sync_n(sync_n), .sdo(sdo), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

//--- bench/pmrb_host.sv
// Host model that frames serial commands and gathers readback bits.
`timescale 1ns/100ps
`default_nettype none
module pmrb_host (
  output logic clk_link,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    clk_link = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
  end

  // Edges with the frame sync high let the block load a pending word.
  task automatic idle(input int n);
    repeat (n) begin
      #32 clk_link = 1'b1;
      #32 clk_link = 1'b0;
    end
  endtask

  // Bits leave MSB first; sdo is sampled just before each rising edge.
  task automatic frame(input logic [28:0] w, input int n, input int gap,
    output logic [28:0] got);
    got = 29'h0000_0000;
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = w[n-1-i];
      #16 got = {got[27:0], sdo};
      #16 clk_link = 1'b1;
      #32 clk_link = 1'b0;
    end
    #16 sync_n = 1'b1;
    sdi = ~sdi;
    #(gap) idle(4);
  endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Testbench: register access, serial readback and refused commands.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import pmrb_pkg::*;
;
  logic clk_sys, srst, clk_link, sync_n, sdi, sdo;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [28:0] got;
  int failures, checks;
  localparam logic [28:0] FLUSH = 29'h00ff_ffff;

  pmrb_top i_pmrb_top (.clk_sys(clk_sys), .srst(srst), .clk_link(clk_link), .sync_n(sync_n),
    .sdi(sdi), .sdo(sdo), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  pmrb_host i_pmrb_host (.clk_link(clk_link), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_rb(input logic [28:0] g, input logic [28:0] e);
    chk({3'h0, g}, {3'h0, e});
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
    bit acked;
    acked = 1'b0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wdat;
    for (int i = 0; i < 20 && !acked; i++) begin
      @(posedge clk_sys);
      acked = (wb_ack_o === 1'b1);
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (!acked) begin
      failures++;
      conclude();
    end
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
    wb(1'b0, adr, 32'h0000_0000);
    chk(rdat, e);
  endtask

  task automatic fr(input logic [28:0] w, input int n, input int gap);
    i_pmrb_host.frame(w, n, gap, got);
  endtask

  function automatic logic [28:0] rcmd(logic [3:0] ch, logic [1:0] op, logic [5:0] a);
    pmrb_cmd_t c;
    c = '{rd: 1'b1, ch: ch, op: op, addr: a, data: 16'h0000};
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic global_reads();
    logic [23:0] val [3];
    logic [7:0] adr [3];
    logic [1:0] op [3];
    val = '{24'h12_3456, 24'ha5_5a0f, 24'h80_0001};
    adr = '{ADR_SYS_CTRL, ADR_CMP_STAT, ADR_ALM_STAT};
    op = '{2'h0, 2'h1, 2'h3};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, adr[i], {8'h00, val[i]});
      fr(rcmd(4'h0, op[i], 6'h00), 29, 500);
      fr(FLUSH, 24, 500);
      chk_rb(got, {5'h00, val[i]});
    end
  endtask

  task automatic pmu_chain();
    logic [23:0] val [4];
    val = '{24'h01_1111, 24'h42_2222, 24'h03_3333, 24'hc4_4444};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ADR_CH0 + 8'(4 * i), {8'h00, val[i]});
    end
    for (int i = 0; i < 4; i++) begin
      fr(rcmd(4'(1 << i), OP_CTL, 6'h00), 29, (i == 2) ? 3000 : 500);
      if (i > 0) begin
        chk_rb(got, {val[i-1], 5'h00});
      end
    end
    fr(FLUSH, 24, 500);
    chk_rb(got, {5'h00, val[3]});
  endtask

  task automatic dac_reads();
    logic [3:0] sets [4];
    logic [1:0] op [4];
    logic [15:0] val [4];
    logic [15:0] ev;
    logic [5:0] adr;
    pmrb_dac_sel_t sel;
    sets = '{4'h0, 4'h5, 4'h6, 4'hb};
    op = '{OP_GAIN, OP_OFFS, OP_INPUT, OP_GAIN};
    val = '{16'habcd, 16'h7fff, 16'h8001, 16'h1235};
    for (int i = 0; i < 4; i++) begin
      sel = '{op: op[i], set: sets[i], ch: 2'(i)};
      ev = (op[i] == OP_GAIN) ? (val[i] & GAIN_MASK) : val[i];
      adr = (sets[i] < 4'h6) ? LO_SET_BASE + {2'h0, sets[i]}
                             : HI_SET_BASE + {2'h0, sets[i]} - 6'h06;
      wb(1'b1, ADR_DAC_SEL, {24'h00_0000, sel});
      wb(1'b1, ADR_DAC_DATA, {16'h0000, val[i]});
      rd_chk(ADR_DAC_DATA, {16'h0000, ev});
      fr(rcmd(4'(1 << i), op[i], adr), 29, 500);
      fr(FLUSH, 24, 500);
      chk_rb(got, {5'h00, op[i], adr, ev});
    end
  endtask

  task automatic bad_reads();
    logic [28:0] cmd [3];
    cmd = '{rcmd(4'h0, OP_OFFS, 6'h00), rcmd(4'h3, OP_CTL, 6'h00),
            rcmd(4'h0, OP_CTL, 6'h00)};
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        wb(1'b1, ADR_CTRL, 32'h0000_0000);
      end
      fr(cmd[i], 29, 500);
      fr(FLUSH, 24, 500);
      // Nothing loads, so sdo first repeats the last flush bit, then echoes the command.
      chk_rb(got, {5'h00, 1'b1, cmd[i][28:6]});
    end
    rd_chk(ADR_STATUS, 32'h0001_000b);
    rd_chk(ADR_CTRL, 32'h0000_0000);
    rd_chk(ADR_LAST_CMD, {3'h0, FLUSH});
    wb(1'b1, ADR_STATUS, 32'h0001_0000);
    rd_chk(ADR_STATUS, 32'h0000_000b);
    rd_chk(8'h30, 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    failures = 0;
    checks = 0;
    // The link side needs its own reset edges before the release.
    i_pmrb_host.idle(4);
    @(posedge clk_sys);
    srst <= 1'b0;
    // The link side leaves reset only after two more link edges.
    i_pmrb_host.idle(3);
    rd_chk(ADR_CTRL, CTRL_RST);
    rd_chk(ADR_DAC_SEL, {24'h00_0000, SEL_RST});
    global_reads();
    pmu_chain();
    dac_reads();
    bad_reads();
    conclude();
  end
endmodule
`default_nettype wire
